/* File: bench/testbench.sv */
// testbench: self-checking bench for the pad function multiplexer
// assumes the design files and pad_mux_map.svh are compiled before it
`timescale 1ns/1ps
`include "pad_mux_map.svh"

module testbench;
   // table entry: low half of offset, config, default, pad slot, input idx
   typedef struct packed {
      logic [15:0] a;
      logic [7:0] c;
      logic [7:0] d;
      logic [3:0] s;
      logic [3:0] i;
   } ent_t;
   logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, lvl;
   logic master_reset_n, fdp, fsn, fd, bs2, fso;
   logic [31:0] avs_address, avs_writedata, avs_readdata, q;
   logic [9:0] pad_in, pad_out, pad_oe, gin;
   logic [19:0] pdr;
   logic [14:0] po;
   int err_total, samples_checked, cyc;
   ent_t tb[36];

   // every peripheral input follows lvl so one knob exercises all routes
   module_pad_function_mux dut (
      .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .master_reset_n(master_reset_n), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_drive(pdr),
      .gpio_out({10{lvl}}), .gpio_oe({10{lvl}}), .gpio_in(gin),
      .generic_spi_select_out(lvl), .generic_spi_select_oe(lvl),
      .generic_spi_select_in(po[14]), .card_command_out(lvl),
      .card_command_oe(lvl), .card_command_in(po[0]),
      .audio_clock_out(lvl), .audio_frame_sync(lvl),
      .i2c_clock_low(lvl), .i2c_clock_in(po[1]), .i2c_data_low(lvl),
      .i2c_data_in(po[2]), .first_serial_transmit(lvl),
      .first_serial_receive(po[3]), .second_serial_transmit(lvl),
      .second_serial_receive(po[4]), .camera_data_bit7(po[5]),
      .camera_vertical_sync(po[6]), .camera_horizontal_sync(po[7]),
      .timer_capture_3(po[8]), .timer_capture_4(po[9]),
      .timer_capture_6(po[10]), .scan_data_in(po[11]),
      .scan_data_out(lvl), .scan_clock(po[12]), .scan_mode_out(lvl),
      .scan_mode_oe(lvl), .scan_mode_in(po[13]), .pwm_out_0(lvl),
      .timer_pwm_2(lvl), .timer_pwm_3(lvl), .ext_oscillator_enable(lvl),
      .boot_sense_2(bs2), .flash_select_ctrl_n(lvl),
      .serial_flash_select_n(fsn), .serial_flash_select_oe(fso),
      .flash_data_pad(fdp), .flash_data(fd));

   // 250 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // hang guard, far above the several hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one avalon transfer; extra edge after release avoids double drives
   task automatic bus(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      q = avs_readdata;
      if (n == 100) err_total++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input string nm, input logic [31:0] a, e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 32'h0;
      avs_writedata = 32'h0;
      lvl = 1'b0;
      master_reset_n = 1'b1;
      pad_in = 10'h0;
      fdp = 1'b0;
      tb = '{40'he0e418000f, 40'he0e417000f, 40'he0e410000f,
         40'he0e4140005, 40'he0e4150004, 40'he0d013001f,
         40'he0d017001f, 40'he0d010001f, 40'he0d0140016,
         40'he0d01c0018, 40'he0d4140027, 40'he0d4170023,
         40'he0d41c0029, 40'he0f817003f, 40'he0f8150039,
         40'he0fc12114f, 40'he0fc11114b, 40'he10015115f,
         40'he10016115f, 40'he10011115f, 40'he10014115a,
         40'he100121154, 40'he11018116f, 40'he11011116c,
         40'he11410117f, 40'he14010008f, 40'he10419009f,
         40'he10412009f, 40'he10411009f, 40'he0e417000e,
         40'he0e4180000, 40'he0d0150001, 40'he0d4150002,
         40'he11411117d, 40'he0fc191141, 40'he100191152};
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd("tdi cfg", `OFS_TDI, 32'h11);
      rd("tdo cfg", `OFS_TDO, 32'h11);
      rd("tck cfg", `OFS_TCK, 32'h11);
      rd("tms cfg", `OFS_TMS, 32'h11);
      rd("p28 cfg", `OFS_P28, 32'h0);
      chk("idle oe", 32'h0, {26'h0, pad_oe[9:8], pad_oe[3:0]});
      rd("unmapped", 32'h4402e300, 32'h0);
      bus(1'b1, `OFS_P28, 32'h70); // code 3 clamps to 6 mA
      rd("p28 drive cfg", `OFS_P28, 32'h50);
      chk("p28 drive", 32'h2, {30'h0, pdr[17:16]});
      bus(1'b1, `OFS_P28, 32'h0);
      // every listed mode but gpio on pad13, pad22, tdi, tdo and sense2; both levels; restore default afterwards
      foreach (tb[k]) begin
         bus(1'b1, {16'h4402, tb[k].a}, {24'h0, tb[k].c});
         for (int v = 0; v < 2; v++) begin
            lvl <= v[0];
            pad_in <= {10{v[0]}};
            repeat (5) @(posedge clk_sys);
            if (tb[k].i == 4'hf)
               chk($sformatf("out %0d", k), {30'h0, 1'b1, v[0]},
                  {30'h0, pad_oe[tb[k].s] | !v[0], pad_out[tb[k].s]});
            else
               chk($sformatf("in %0d", k), {31'h0, v[0]},
                  {31'h0, po[tb[k].i]});
         end
         bus(1'b1, {16'h4402, tb[k].a}, {24'h0, tb[k].d});
      end
      // all pads read high here, so a gpio input route must show a 1
      bus(1'b1, `OFS_P28, 32'h10);
      repeat (4) @(posedge clk_sys);
      chk("p28 gpio in", 32'h1, {31'h0, gin[8]});
      // unlisted mode floats its pad only; pads show the last write by the negedge after its transfer
      lvl <= 1'b1;
      bus(1'b1, `OFS_P12, 32'h17);
      bus(1'b1, `OFS_P17, 32'h13);
      bus(1'b1, `OFS_P22, 32'h17);
      @(negedge clk_sys);
      chk("p17 unlisted", 32'h0, {31'h0, pad_oe[0]});
      chk("p12 kept", 32'h1, {31'h0, pad_oe[1]});
      chk("p22 timing", 32'h1, {31'h0, pad_oe[3]});
      @(posedge clk_sys);
      // hibernate with two-wire then four-wire debug, then deep sleep
      bus(1'b1, `OFS_SLEEP, 32'h6);
      repeat (2) @(posedge clk_sys);
      chk("hib two-wire", 32'h3, {30'h0, pad_oe[5], pad_out[5]});
      chk("hib sense2", 32'h2, {30'h0, pad_oe[9], pad_out[9]});
      rd("sleep reg", `OFS_SLEEP, 32'h106);
      bus(1'b1, `OFS_SLEEP, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk("hib four-wire", 32'h2, {30'h0, pad_oe[5], pad_out[5]});
      fdp <= 1'b1;
      lvl <= 1'b0;
      bus(1'b1, `OFS_SLEEP, 32'h1);
      repeat (4) @(posedge clk_sys);
      chk("deep flash sel", 32'h3, {30'h0, fso, fsn});
      chk("deep flash data", 32'h0, {31'h0, fd});
      chk("deep sense2", 32'h2, {30'h0, pad_oe[9], pad_out[9]});
      bus(1'b1, `OFS_SLEEP, 32'h0);
      // master reset pin low floats every muxed pad
      master_reset_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk("reset float", 32'h0, {22'h0, pad_oe});
      chk("reset flash data", 32'h0, {31'h0, fd});
      master_reset_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk("boot sense2", 32'h1, {31'h0, bs2});
      rd("p12 after reset", `OFS_P12, 32'h0);
      wrap_up();
   end
endmodule // testbench

/* File: verilog/module_pad_function_mux.sv */
// module_pad_function_mux: function mux for one slice of module pads
// assumes one 250 MHz clock, avalon-mm master, pins async to clk_sys
//
// Overview of operation
// R01 - pad17 modes: gpio, serial2 rx, spi cs, camera, card
// R02 - pad12 modes: gpio, audio clk, vsync, i2c, tx, capture
// R03 - pad13 modes: gpio, i2c data, hsync, rx, capture
// R04 - pad22 modes: gpio, audio frame sync, capture 4
// R05 - scan-in pad defaults mode 1, else gpio, tx, i2c
// R06 - scan-out pad defaults mode 1, plus pwm, i2c, audio
// R07 - hibernate: scan-out high two-wire, low four-wire
// R08 - scan-clock pad defaults mode 1, mode 8 pwm
// R09 - scan-mode pad defaults mode 1, mode 0 gpio
// R10 - gpio28 pad offers only gpio in mode 0
// R11 - sense2 pad: gpio, pwm, audio, oscillator enable
// R12 - flash select fixed, held high in deep sleep
// R13 - flash data-in fixed, quiet in sleep and reset
// R14 - master reset low floats every muxed pad
// R15 - after boot debug pads mode 1, others float
// R16 - per-pad drive strength 2, 4 or 6 mA
// R17 - unlisted mode floats pad, others untouched
// R18 - config write reaches pad next cycle, no glitch
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pad_mux_map.svh"

module module_pad_function_mux (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic master_reset_n,
   input wire logic [9:0] pad_in,
   output logic [9:0] pad_out,
   output logic [9:0] pad_oe,
   output logic [19:0] pad_drive,
   input wire logic [9:0] gpio_out,
   input wire logic [9:0] gpio_oe,
   output logic [9:0] gpio_in,
   input wire logic generic_spi_select_out,
   input wire logic generic_spi_select_oe,
   output logic generic_spi_select_in,
   input wire logic card_command_out,
   input wire logic card_command_oe,
   output logic card_command_in,
   input wire logic audio_clock_out,
   input wire logic audio_frame_sync,
   input wire logic i2c_clock_low,
   output logic i2c_clock_in,
   input wire logic i2c_data_low,
   output logic i2c_data_in,
   input wire logic first_serial_transmit,
   output logic first_serial_receive,
   input wire logic second_serial_transmit,
   output logic second_serial_receive,
   output logic camera_data_bit7,
   output logic camera_vertical_sync,
   output logic camera_horizontal_sync,
   output logic timer_capture_3,
   output logic timer_capture_4,
   output logic timer_capture_6,
   output logic scan_data_in,
   input wire logic scan_data_out,
   output logic scan_clock,
   input wire logic scan_mode_out,
   input wire logic scan_mode_oe,
   output logic scan_mode_in,
   input wire logic pwm_out_0,
   input wire logic timer_pwm_2,
   input wire logic timer_pwm_3,
   input wire logic ext_oscillator_enable,
   output logic boot_sense_2,
   input wire logic flash_select_ctrl_n,
   output logic serial_flash_select_n,
   output logic serial_flash_select_oe,
   input wire logic flash_data_pad,
   output logic flash_data
);

   pad_mux_pkg::pad_cfg_t cfg [0:9];
   pad_mux_pkg::power_state_t pwr;
   logic two_wire;
   logic [11:0] pin_meta;
   logic [11:0] pin_sync;
   logic mrst_ok;
   logic [3:0] mode [0:9];
   logic [9:0] conn;
   logic [9:0] next_out;
   logic [9:0] next_oe;
   logic [3:0] bus_ix;
   logic bus_hit;
   logic rx_live;
   logic is_deep;
   logic is_hib;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // 1 when pad c is connected and set to mode want
   function automatic logic is_sel(input logic c, input logic [3:0] md,
                                   input logic [3:0] want);
      return c && (md == want);
   endfunction

   // address decode; unmapped words give IX_NONE
   function automatic logic [3:0] reg_index(input logic [31:0] a);
      if (a == `OFS_P17) return 4'h0;
      else if (a == `OFS_P12) return 4'h1;
      else if (a == `OFS_P13) return 4'h2;
      else if (a == `OFS_P22) return 4'h3;
      else if (a == `OFS_TDI) return 4'h4;
      else if (a == `OFS_TDO) return 4'h5;
      else if (a == `OFS_TCK) return 4'h6;
      else if (a == `OFS_TMS) return 4'h7;
      else if (a == `OFS_P28) return 4'h8;
      else if (a == `OFS_SOP) return 4'h9;
      else if (a == `OFS_SLEEP) return `IX_SLEEP;
      else return `IX_NONE;
   endfunction

   // drive code 3 is not a setting; keep it at the strongest one
   function automatic logic [1:0] clamp_drive(input logic [1:0] d);
      return (d == 2'h3) ? `DRV_6MA : d;
   endfunction

   // two flops on every pin; only stage two is read by logic
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_meta <= 12'h000;
         pin_sync <= 12'h000;
      end else begin
         pin_meta <= {master_reset_n, flash_data_pad, pad_in};
         pin_sync <= pin_meta;
      end
   end
   assign mrst_ok = pin_sync[11];

   assign bus_ix = reg_index(avs_address);
   assign bus_hit = (avs_read || avs_write) && avs_waitrequest;
   assign is_deep = (pwr == pad_mux_pkg::PWR_DEEP);
   assign is_hib = (pwr == pad_mux_pkg::PWR_HIB);
   assign rx_live = mrst_ok && !is_hib;

   // one wait cycle per access; write lands at the answering edge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (bus_hit) begin
         avs_waitrequest <= 1'b0;
         if (bus_ix < 4'ha)
            avs_readdata <= {25'h0, cfg[bus_ix]};
         else if (bus_ix == `IX_SLEEP)
            avs_readdata <= {23'h0, mrst_ok, 5'h0, two_wire, pwr};
         else
            avs_readdata <= 32'h0000_0000;  // unmapped reads zero
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // pad configs; master reset returns them to boot defaults
   always_ff @(posedge clk_sys) begin
      if (rst || !mrst_ok) begin
         for (int i = 0; i < `NUM_PADS; i++)
            cfg[i] <= `CFG_RST_GEN;  // [R15]
         cfg[`PX_TDI] <= `CFG_RST_DBG;  // [R05] [R15]
         cfg[`PX_TDO] <= `CFG_RST_DBG;  // [R06]
         cfg[`PX_TCK] <= `CFG_RST_DBG;  // [R08]
         cfg[`PX_TMS] <= `CFG_RST_DBG;  // [R09]
      end else if (bus_hit && avs_write && avs_byteenable[0] &&
                   bus_ix < 4'ha) begin
         // only the addressed pad changes, so others never glitch
         cfg[bus_ix] <= {clamp_drive(avs_writedata[6:5]),
                         avs_writedata[4:0]};  // [R16] [R18]
      end
   end

   // sleep register: power state and debug wiring style
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwr <= pad_mux_pkg::PWR_ACTIVE;
         two_wire <= 1'b0;
      end else if (bus_hit && avs_write && avs_byteenable[0] &&
                   bus_ix == `IX_SLEEP) begin
         pwr <= pad_mux_pkg::power_state_t'(avs_writedata[1:0]);
         two_wire <= avs_writedata[`SLP_TWO_WIRE];
      end
   end

   always_comb begin
      for (int i = 0; i < `NUM_PADS; i++) begin
         mode[i] = cfg[i][3:0];
         conn[i] = cfg[i][`CONNECT_BIT];
         pad_drive[2*i +: 2] = cfg[i][6:5];  // [R16]
      end
   end

   // output mux; unlisted modes fall to default and float the pad
   always_comb begin
      next_out = 10'h000;
      next_oe = 10'h000;
      for (int i = 0; i < `NUM_PADS; i++) begin
         if (is_sel(conn[i], mode[i], `M_GPIO) && i != `PX_TCK) begin
            next_out[i] = gpio_out[i];
            next_oe[i] = gpio_oe[i] || (i == `PX_SOP);  // sense2 output-only
         end
      end
      if (conn[`PX_P17]) begin
         case (mode[`PX_P17])
            `M17_SPI_CS: begin  // [R01]
               next_out[0] = generic_spi_select_out;
               next_oe[0] = generic_spi_select_oe;
            end
            `M17_CARD_CMD: begin  // [R01]
               next_out[0] = card_command_out;
               next_oe[0] = card_command_oe;
            end
            default: ;  // [R17]
         endcase
      end
      if (conn[`PX_P12]) begin
         case (mode[`PX_P12])
            `M12_AUD_CLK: begin  // [R02]
               next_out[1] = audio_clock_out;
               next_oe[1] = 1'b1;
            end
            `M12_I2C_SCL: next_oe[1] = i2c_clock_low;  // [R02] open drain
            `M12_SER1_TX: begin  // [R02]
               next_out[1] = first_serial_transmit;
               next_oe[1] = 1'b1;
            end
            default: ;
         endcase
      end
      if (is_sel(conn[2], mode[2], `M13_I2C_SDA))
         next_oe[2] = i2c_data_low;  // [R03]
      if (is_sel(conn[3], mode[3], `M22_AUD_FS)) begin
         next_out[3] = audio_frame_sync;  // [R04]
         next_oe[3] = 1'b1;
      end
      if (conn[`PX_TDI]) begin
         case (mode[`PX_TDI])
            `M23_SER2_TX: begin  // [R05]
               next_out[4] = second_serial_transmit;
               next_oe[4] = 1'b1;
            end
            `M23_I2C_SCL: next_oe[4] = i2c_clock_low;  // [R05]
            default: ;
         endcase
      end
      if (conn[`PX_TDO]) begin
         case (mode[`PX_TDO])
            `M_SCAN: begin  // [R06]
               next_out[5] = scan_data_out;
               next_oe[5] = 1'b1;
            end
            `M24_PWM: begin  // [R06]
               next_out[5] = pwm_out_0;
               next_oe[5] = 1'b1;
            end
            `M24_I2C_SDA: next_oe[5] = i2c_data_low;  // [R06]
            `M24_AUD_FS: begin  // [R06]
               next_out[5] = audio_frame_sync;
               next_oe[5] = 1'b1;
            end
            default: ;
         endcase
      end
      if (is_sel(conn[6], mode[6], `M28_PWM3)) begin
         next_out[6] = timer_pwm_3;  // [R08]
         next_oe[6] = 1'b1;
      end
      if (is_sel(conn[7], mode[7], `M_SCAN)) begin
         next_out[7] = scan_mode_out;  // [R09]
         next_oe[7] = scan_mode_oe;
      end
      if (conn[`PX_SOP]) begin
         case (mode[`PX_SOP])
            `M25_PWM2: begin  // [R11]
               next_out[9] = timer_pwm_2;
               next_oe[9] = 1'b1;
            end
            `M25_AUD_FS: begin  // [R11]
               next_out[9] = audio_frame_sync;
               next_oe[9] = 1'b1;
            end
            `M25_OSC: begin  // [R11]
               next_out[9] = ext_oscillator_enable;
               next_oe[9] = 1'b1;
            end
            default: ;
         endcase
      end
   end

   // pad flops: reset floats, hibernate floats all but scan-out and sense2, deep sleep holds all but sense2 and serial tx
   always_ff @(posedge clk_sys) begin
      if (rst || !mrst_ok) begin
         pad_out <= 10'h000;
         pad_oe <= 10'h000;  // [R14]
      end else if (is_hib) begin
         pad_oe <= 10'h000;
         pad_out <= 10'h000;
         pad_oe[`PX_TDO] <= 1'b1;
         pad_out[`PX_TDO] <= two_wire;  // [R07]
         pad_oe[`PX_SOP] <= 1'b1;  // [R11] oscillator off
      end else if (is_deep) begin
         // held pads keep the link idle while the core sleeps
         pad_out[`PX_SOP] <= 1'b0;  // [R11]
         pad_oe[`PX_SOP] <= 1'b1;
         if (is_sel(conn[1], mode[1], `M12_SER1_TX))
            pad_out[`PX_P12] <= 1'b1;
         if (is_sel(conn[4], mode[4], `M23_SER2_TX))
            pad_out[`PX_TDI] <= 1'b1;
      end else begin
         pad_out <= next_out;  // [R18]
         pad_oe <= next_oe;
      end
   end

   // fixed flash pads: select held high in deep sleep
   always_ff @(posedge clk_sys) begin
      if (rst || !mrst_ok || is_hib) begin
         serial_flash_select_n <= 1'b1;
         serial_flash_select_oe <= 1'b0;
      end else begin
         serial_flash_select_n <= is_deep || flash_select_ctrl_n;  // [R12]
         serial_flash_select_oe <= 1'b1;
      end
   end

   // flash data in never drives; its input reads 0 when asleep
   always_ff @(posedge clk_sys) begin
      if (rst)
         flash_data <= 1'b0;
      else
         flash_data <= mrst_ok && (pwr == pad_mux_pkg::PWR_ACTIVE) &&
                       pin_sync[10];  // [R13]
   end

   // sense2 strap caught at last clock before master reset releases
   always_ff @(posedge clk_sys) begin
      if (rst)
         boot_sense_2 <= 1'b0;
      else if (!mrst_ok)
         boot_sense_2 <= pin_sync[`PX_SOP];
   end

   // input routing to peripherals; first listed pad wins on sharing
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gpio_in <= 10'h000;
         generic_spi_select_in <= 1'b0;
         card_command_in <= 1'b0;
         second_serial_receive <= 1'b0;
         camera_data_bit7 <= 1'b0;
         camera_vertical_sync <= 1'b0;
         camera_horizontal_sync <= 1'b0;
         i2c_clock_in <= 1'b0;
         i2c_data_in <= 1'b0;
         first_serial_receive <= 1'b0;
         timer_capture_3 <= 1'b0;
         timer_capture_4 <= 1'b0;
         timer_capture_6 <= 1'b0;
         scan_data_in <= 1'b0;
         scan_clock <= 1'b0;
         scan_mode_in <= 1'b0;
      end else begin
         for (int i = 0; i < `NUM_PADS; i++)
            gpio_in[i] <= rx_live && is_sel(conn[i], mode[i], `M_GPIO) &&
                          pin_sync[i] && (i != `PX_TCK);  // [R10] [R17]
         generic_spi_select_in <= rx_live && pin_sync[0] &&
            is_sel(conn[0], mode[0], `M17_SPI_CS);  // [R01]
         card_command_in <= rx_live && pin_sync[0] &&
            is_sel(conn[0], mode[0], `M17_CARD_CMD);
         camera_data_bit7 <= rx_live && pin_sync[0] &&
            is_sel(conn[0], mode[0], `M17_CAM_D7);
         second_serial_receive <= rx_live &&
            (is_sel(conn[0], mode[0], `M17_SER2_RX) ? pin_sync[0] :
             is_sel(conn[5], mode[5], `M24_SER2_RX) && pin_sync[5]);
         camera_vertical_sync <= rx_live && pin_sync[1] &&
            is_sel(conn[1], mode[1], `M12_CAM_VS);  // [R02]
         timer_capture_3 <= rx_live && pin_sync[1] &&
            is_sel(conn[1], mode[1], `M12_CAP3);
         i2c_clock_in <= rx_live &&
            (is_sel(conn[1], mode[1], `M12_I2C_SCL) ? pin_sync[1] :
             is_sel(conn[4], mode[4], `M23_I2C_SCL) && pin_sync[4]);
         camera_horizontal_sync <= rx_live && pin_sync[2] &&
            is_sel(conn[2], mode[2], `M13_CAM_HS);  // [R03]
         first_serial_receive <= rx_live && pin_sync[2] &&
            is_sel(conn[2], mode[2], `M13_SER1_RX);
         i2c_data_in <= rx_live &&
            (is_sel(conn[2], mode[2], `M13_I2C_SDA) ? pin_sync[2] :
             is_sel(conn[5], mode[5], `M24_I2C_SDA) && pin_sync[5]);
         timer_capture_4 <= rx_live &&
            (is_sel(conn[2], mode[2], `M13_CAP4) ? pin_sync[2] :
             is_sel(conn[3], mode[3], `M22_CAP4) && pin_sync[3]);  // [R04]
         timer_capture_6 <= rx_live && pin_sync[5] &&
            is_sel(conn[5], mode[5], `M24_CAP6);  // [R06]
         scan_data_in <= rx_live && pin_sync[4] &&
            is_sel(conn[4], mode[4], `M_SCAN);  // [R05]
         scan_clock <= rx_live && pin_sync[6] &&
            is_sel(conn[6], mode[6], `M_SCAN);  // [R08]
         scan_mode_in <= rx_live && pin_sync[7] &&
            is_sel(conn[7], mode[7], `M_SCAN);  // [R09]
      end
   end

   property p_rst_float;
      !mrst_ok |=> (pad_oe == 10'h000) && !serial_flash_select_oe;
   endproperty
   a_rst_float: assert property (p_rst_float)  // [R14]
      else $error("pad driven during master reset");

   property p_boot_modes;
      !mrst_ok |=> cfg[`PX_TDI] == `CFG_RST_DBG &&
                   cfg[`PX_TMS] == `CFG_RST_DBG &&
                   cfg[`PX_P17] == `CFG_RST_GEN;
   endproperty
   a_boot_modes: assert property (p_boot_modes)  // [R15]
      else $error("boot pad modes wrong");

   property p_flash_deep;
      mrst_ok && is_deep |=> serial_flash_select_n;
   endproperty
   a_flash_deep: assert property (p_flash_deep)  // [R12]
      else $error("flash selected in deep sleep");

   property p_flash_quiet;
      (!mrst_ok || pwr != pad_mux_pkg::PWR_ACTIVE) |=> !flash_data;
   endproperty
   a_flash_quiet: assert property (p_flash_quiet)  // [R13]
      else $error("flash data passed while asleep");

   property p_hib_tdo;
      mrst_ok && is_hib |=>
         pad_oe[`PX_TDO] && pad_out[`PX_TDO] == $past(two_wire);
   endproperty
   a_hib_tdo: assert property (p_hib_tdo)  // [R07]
      else $error("scan-out pad wrong in hibernate");

   property p_sop_sleep;
      mrst_ok && (is_deep || is_hib) |=> pad_oe[9] && !pad_out[9];
   endproperty
   a_sop_sleep: assert property (p_sop_sleep)  // [R11]
      else $error("oscillator enable not low in sleep");

   property p_p17_cs;
      mrst_ok && !is_hib && !is_deep && is_sel(conn[0], mode[0], 4'h7)
      |=> pad_oe[0] == $past(generic_spi_select_oe) &&
          pad_out[0] == $past(generic_spi_select_out);
   endproperty
   a_p17_cs: assert property (p_p17_cs)  // [R01]
      else $error("pad17 not carrying spi select");

   property p_p12_tx;
      mrst_ok && pwr == pad_mux_pkg::PWR_ACTIVE &&
      is_sel(conn[1], mode[1], 4'h7)
      |=> pad_oe[1] && pad_out[1] == $past(first_serial_transmit);
   endproperty
   a_p12_tx: assert property (p_p12_tx)  // [R02]
      else $error("pad12 not carrying serial transmit");

   property p_unlisted;
      mrst_ok && pwr == pad_mux_pkg::PWR_ACTIVE &&
      conn[0] && mode[0] == 4'h3 |=> !pad_oe[0];
   endproperty
   a_unlisted: assert property (p_unlisted)  // [R17]
      else $error("unlisted mode drives pad17");

   property p_write_lands;
      mrst_ok && avs_write && avs_waitrequest && avs_byteenable[0] &&
      avs_address == `OFS_P22 ##1 mrst_ok
      |-> cfg[3][4:0] == $past(avs_writedata[4:0]) && !avs_waitrequest;
   endproperty
   a_write_lands: assert property (p_write_lands)  // [R18]
      else $error("config write not applied");

   c_hib_two_wire: cover property (mrst_ok && is_hib && two_wire);
   c_p13_hsync: cover property (camera_horizontal_sync);
   c_read_back: cover property (avs_read && !avs_waitrequest);

endmodule // module_pad_function_mux

/* File: verilog/pad_mux_map.svh */
// pad_mux_map.svh: offsets, fields, reset values and mode codes
// assumes byte addresses on a 32-bit avalon bus, one word per register
`ifndef PAD_MUX_MAP_SVH
`define PAD_MUX_MAP_SVH
`define NUM_PADS 10
// register byte addresses
`define OFS_P17 32'h4402e0e4
`define OFS_P12 32'h4402e0d0
`define OFS_P13 32'h4402e0d4
`define OFS_P22 32'h4402e0f8
`define OFS_TDI 32'h4402e0fc
`define OFS_TDO 32'h4402e100
`define OFS_TCK 32'h4402e110
`define OFS_TMS 32'h4402e114
`define OFS_P28 32'h4402e140
`define OFS_SOP 32'h4402e104
`define OFS_SLEEP 32'h4402e200
// pad slots in the pad vectors, then register indices of sleep and unmapped words
`define PX_P17 0
`define PX_P12 1
`define PX_P13 2
`define PX_P22 3
`define PX_TDI 4
`define PX_TDO 5
`define PX_TCK 6
`define PX_TMS 7
`define PX_P28 8
`define PX_SOP 9
`define IX_SLEEP 4'he
`define IX_NONE 4'hf
// pad config fields: [3:0] mode, [4] connect, [6:5] drive
`define CONNECT_BIT 4
`define CFG_RST_GEN 7'h00
`define CFG_RST_DBG 7'h11
`define DRV_6MA 2'h2
// sleep register fields
`define SLP_TWO_WIRE 2
`define SLP_RST_SEEN 8
// mode codes
`define M_GPIO 4'h0
`define M_SCAN 4'h1
`define M17_SER2_RX 4'h5
`define M17_SPI_CS 4'h7
`define M17_CAM_D7 4'h4
`define M17_CARD_CMD 4'h8
`define M12_AUD_CLK 4'h3
`define M12_CAM_VS 4'h4
`define M12_I2C_SCL 4'h5
`define M12_SER1_TX 4'h7
`define M12_CAP3 4'hc
`define M13_I2C_SDA 4'h5
`define M13_CAM_HS 4'h4
`define M13_SER1_RX 4'h7
`define M13_CAP4 4'hc
`define M22_AUD_FS 4'h7
`define M22_CAP4 4'h5
`define M23_SER2_TX 4'h2
`define M23_I2C_SCL 4'h9
`define M24_PWM 4'h5
`define M24_I2C_SDA 4'h9
`define M24_AUD_FS 4'h6
`define M24_SER2_RX 4'h2
`define M24_CAP6 4'h4
`define M28_PWM3 4'h8
`define M25_PWM2 4'h9
`define M25_AUD_FS 4'h2
`define M25_OSC 4'h1
`endif

/* File: verilog/pad_mux_pkg.sv */
// pad_mux_pkg: types shared by the pad function multiplexer
// assumes pad_mux_map.svh supplies every numeric constant except the power state codes and the config width
package pad_mux_pkg;
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'h0,
      PWR_DEEP = 2'h1,
      PWR_HIB = 2'h2
   } power_state_t;
   typedef logic [6:0] pad_cfg_t;
endpackage
